// file: tb_usb_endpoint_transaction_handler.sv
// self-checking bench of the endpoint transaction handler
`include "usbe_regs.svh"
module tb_usb_endpoint_transaction_handler;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] csr_a = `USBE_OFF_CSR;
    localparam logic [7:0] fdr_a = `USBE_OFF_FDR;
    logic        clock_i = '0, rst_i = '1, s_axi_bready_i = '0, s_axi_rready_i = '0;
    logic        s_axi_awvalid_i = '0, s_axi_wvalid_i = '0, s_axi_arvalid_i = '0;
    logic [7:0]  s_axi_awaddr_i = '0, s_axi_araddr_i = '0, rx_data_i, tx_data_o;
    logic [31:0] s_axi_wdata_i = '0, s_axi_rdata_o, rd, seed = 32'h46b5;
    logic [3:0]  s_axi_wstrb_i = '0;
    logic        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o;
    logic        s_axi_rvalid_o, tok_valid_i, rx_valid_i, rx_end_i, host_ack_i;
    logic        hs_valid_o, tx_valid_o, tx_last_o, tx_zero_o, ep_irq_o;
    logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, tok_pid_i, hs_code_o, hs;
    logic [7:0]  q[$], got_q[$], b0[$], b1[$];
    int          errors = 0, checks = 0;
    bit          ok;
    always #2 clock_i = ~clock_i;
    usbe_ep_txn usbe_ep_txn_i (.clock_i, .rst_i, .s_axi_awvalid_i, .s_axi_awready_o,
        .s_axi_awaddr_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_wdata_i, .s_axi_wstrb_i,
        .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_bresp_o, .s_axi_arvalid_i, .s_axi_arready_o,
        .s_axi_araddr_i, .s_axi_rvalid_o, .s_axi_rready_i, .s_axi_rdata_o, .s_axi_rresp_o,
        .tok_valid_i, .tok_pid_i, .rx_valid_i, .rx_data_i, .rx_end_i, .host_ack_i,
        .hs_valid_o, .hs_code_o, .tx_valid_o, .tx_data_o, .tx_last_o, .tx_zero_o, .ep_irq_o);
    usbe_host_model usbe_host_model_i (.clock_i, .hs_valid_i(hs_valid_o),
        .hs_code_i(hs_code_o), .tx_valid_i(tx_valid_o), .tx_data_i(tx_data_o),
        .tx_last_i(tx_last_o), .tx_zero_i(tx_zero_o), .tok_valid_o(tok_valid_i),
        .tok_pid_o(tok_pid_i), .rx_valid_o(rx_valid_i), .rx_data_o(rx_data_i),
        .rx_end_o(rx_end_i), .host_ack_o(host_ack_i));
    // ****************************************
    // checking and bus tasks
    // ****************************************
    task automatic give_verdict;
        if (errors == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    task automatic gen(input int n);
        q = {};
        repeat (n) begin
            seed ^= seed << 13;
            seed ^= seed >> 17;
            seed ^= seed << 5;
            q.push_back(seed[7:0]);
        end
    endtask : gen
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        bit ag, wg;
        ag = 0;
        wg = 0;
        s_axi_awaddr_i <= a;
        s_axi_wdata_i <= d;
        s_axi_wstrb_i <= 4'hf;
        s_axi_awvalid_i <= 1;
        s_axi_wvalid_i <= 1;
        s_axi_bready_i <= 1;
        while (!(ag && wg)) begin
            @(posedge clock_i);
            if (!ag && s_axi_awready_o) begin
                ag = 1;
                s_axi_awvalid_i <= 0;
            end
            if (!wg && s_axi_wready_o) begin
                wg = 1;
                s_axi_wvalid_i <= 0;
            end
        end
        do @(posedge clock_i); while (!s_axi_bvalid_o);
        chk(s_axi_bresp_o, r);
    endtask : axw
    task automatic axr(input logic [7:0] a, input logic [1:0] r);
        s_axi_araddr_i <= a;
        s_axi_arvalid_i <= 1;
        s_axi_rready_i <= 1;
        do @(posedge clock_i); while (!s_axi_arready_o);
        s_axi_arvalid_i <= 0;
        do @(posedge clock_i); while (!s_axi_rvalid_o);
        rd = s_axi_rdata_o;
        chk(s_axi_rresp_o, r);
    endtask : axr
    task automatic csr(input logic [31:0] m, input logic [31:0] e);
        axr(csr_a, 0);
        chk(rd & m, e);
    endtask : csr
    task automatic push(input int n);
        gen(n);
        foreach (q[i]) axw(fdr_a, {24'h0, q[i]}, 0);
    endtask : push
    task automatic pop;
        foreach (q[i]) begin
            axr(fdr_a, 0);
            chk(rd[7:0], q[i]);
        end
    endtask : pop
    task automatic in_chk(input bit ack, input logic [1:0] h, input bit gh);
        usbe_host_model_i.fetch(ack, got_q, hs, ok);
        chk(ok, gh);
        if (gh) chk(hs, h);
        else chk(got_q.size(), q.size());
        if (!gh) foreach (q[i]) chk(got_q[i], q[i]);
    endtask : in_chk
    task automatic out_chk(input logic [1:0] pid, input logic [1:0] h, input bit gh);
        usbe_host_model_i.send(pid, q, hs, ok);
        chk(ok, gh);
        if (gh) chk(hs, h);
    endtask : out_chk
    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        // generous: the whole run is a few hundred cycles, the limit is 20000
        #80000;
        errors++;
        give_verdict();
    end
    initial begin
        repeat (5) @(posedge clock_i);
        rst_i <= 0;
        @(posedge clock_i);
        csr(32'hffffffff, 0);
        axr(8'h0c, `USBE_RESP_SLVERR);
        chk(rd, 0);
        axw(8'h0c, 32'hff, `USBE_RESP_SLVERR);
        csr(32'h10, 0);
        push(3);
        axw(csr_a, 32'h5f, 0);
        csr(32'h11, 32'h10);
        in_chk(1, 0, 0);
        csr(32'h11, 32'h01);
        chk(ep_irq_o, 1);
        in_chk(0, `USBE_HS_NAK, 1);
        axw(csr_a, 32'h4e, 0);
        csr(32'h1, 0);
        chk(ep_irq_o, 0);
        push(2);
        axw(csr_a, 32'h5f, 0);
        axw(csr_a, 32'h4f, 0);
        axw(`USBE_OFF_RST, 0, 0);
        in_chk(0, `USBE_HS_NAK, 1);
        gen(3);
        b0 = q;
        out_chk(`USBE_PID_OUT, `USBE_HS_ACK, 1);
        csr(32'h7f004f, 32'h30002);
        chk(ep_irq_o, 1);
        gen(2);
        out_chk(`USBE_PID_OUT, `USBE_HS_NAK, 1);
        q = b0;
        pop();
        axw(csr_a, 32'h4d, 0);
        csr(32'h2, 0);
        chk(ep_irq_o, 0);
        axw(csr_a, 32'h6f, 0);
        in_chk(0, `USBE_HS_STALL, 1);
        csr(32'h8, 32'h8);
        chk(ep_irq_o, 1);
        gen(1);
        out_chk(`USBE_PID_OUT, `USBE_HS_STALL, 1);
        axw(csr_a, 32'h47, 0);
        csr(32'h28, 0);
        gen(8);
        out_chk(`USBE_PID_SETUP, `USBE_HS_ACK, 1);
        csr(32'h4, 32'h4);
        chk(ep_irq_o, 1);
        pop();
        axw(csr_a, 32'h4b, 0);
        axw(csr_a, 32'h14f, 0);
        gen(2);
        out_chk(`USBE_PID_OUT, 0, 0);
        axw(csr_a, 32'hcf, 0);
        gen(2);
        b0 = q;
        out_chk(`USBE_PID_OUT, `USBE_HS_ACK, 1);
        gen(3);
        b1 = q;
        out_chk(`USBE_PID_OUT, `USBE_HS_ACK, 1);
        gen(1);
        out_chk(`USBE_PID_OUT, `USBE_HS_NAK, 1);
        csr(32'h42, 32'h42);
        q = b0;
        pop();
        axw(csr_a, 32'hcd, 0);
        csr(32'h7f0042, 32'h30040);
        q = b1;
        pop();
        axw(csr_a, 32'h8f, 0);
        csr(32'h43, 0);
        push(2);
        b0 = q;
        axw(csr_a, 32'hdf, 0);
        push(3);
        b1 = q;
        q = b0;
        in_chk(1, 0, 0);
        csr(32'h11, 32'h01);
        axw(csr_a, 32'hdf, 0);
        axw(csr_a, 32'hde, 0);
        q = b1;
        in_chk(1, 0, 0);
        csr(32'h11, 32'h01);
        axw(csr_a, 32'hdf, 0);
        axw(csr_a, 32'hde, 0);
        q = {};
        in_chk(1, 0, 0);
        csr(32'h11, 32'h01);
        axw(csr_a, 32'hce, 0);
        push(1);
        axw(csr_a, 32'hdf, 0);
        axw(csr_a, 32'hcf, 0);
        csr(32'h10, 0);
        axw(csr_a, 32'hdf, 0);
        csr(32'h10, 32'h10);
        axw(csr_a, 32'hcf, 0);
        axw(`USBE_OFF_RST, 0, 0);
        in_chk(0, `USBE_HS_NAK, 1);
        give_verdict();
    end
endmodule : tb_usb_endpoint_transaction_handler

// file: usbe_ep_txn.sv
// one usb endpoint: in/out/setup transactions, ping-pong banks, stall, axi4-lite registers
// Notes on behaviour
// - transmit-done is set after the host acks the in packet; isochronous in sets it at the last byte without an ack.
// - endpoint interrupt stays pending while transmit-done is set.
// - ping-pong endpoints have two banks, each passed between firmware and hardware in turn; both can be full with firmware at once.
// - in request with nothing armed is answered with nak.
// - isochronous traffic only on dual-bank endpoints.
// - single-bank out is nakked while firmware owns the fifo, else stored and acked.
// - out data in bank 0 sets bank-0-full, interrupt pending until cleared.
// - received byte count readable in the control/status register.
// - ping-pong out acks bank 0, takes next into bank 1, refills when released.
// - bank 1 reception sets bank-1-full, interrupt pending until cleared.
// - while force-stall is set, in and out transactions get a stall handshake; an isochronous out gets no handshake, only stall-sent is set.
// - after a stall, stall-sent is set, interrupt pending until cleared.
// - setup is acked automatically, sets setup flag, interrupt pending until cleared.
//
// The address map and register access over AXI4-Lite were decided locally.
`include "usbe_regs.svh"
module usbe_ep_txn
    import usbe_pkg::*;
(
    input  wire logic        clock_i,
    input  wire logic        rst_i,
    input  wire logic        s_axi_awvalid_i,
    output logic             s_axi_awready_o,
    input  wire logic [7:0]  s_axi_awaddr_i,
    input  wire logic        s_axi_wvalid_i,
    output logic             s_axi_wready_o,
    input  wire logic [31:0] s_axi_wdata_i,
    input  wire logic [3:0]  s_axi_wstrb_i,
    output logic             s_axi_bvalid_o,
    input  wire logic        s_axi_bready_i,
    output logic [1:0]       s_axi_bresp_o,
    input  wire logic        s_axi_arvalid_i,
    output logic             s_axi_arready_o,
    input  wire logic [7:0]  s_axi_araddr_i,
    output logic             s_axi_rvalid_o,
    input  wire logic        s_axi_rready_i,
    output logic [31:0]      s_axi_rdata_o,
    output logic [1:0]       s_axi_rresp_o,
    input  wire logic        tok_valid_i,
    input  wire logic [1:0]  tok_pid_i,
    input  wire logic        rx_valid_i,
    input  wire logic [7:0]  rx_data_i,
    input  wire logic        rx_end_i,
    input  wire logic        host_ack_i,
    output logic             hs_valid_o,
    output logic [1:0]       hs_code_o,
    output logic             tx_valid_o,
    output logic [7:0]       tx_data_o,
    output logic             tx_last_o,
    output logic             tx_zero_o,
    output logic             ep_irq_o
);
    usbe_state_t s_reg;
    usbe_state_t s_next;

    // 0 csr, 1 fifo data, 2 endpoint reset, 3 unmapped
    function automatic logic [1:0] reg_sel(input logic [7:0] a);
        unique case (a)
            `USBE_OFF_CSR: reg_sel = 2'h0;
            `USBE_OFF_FDR: reg_sel = 2'h1;
            `USBE_OFF_RST: reg_sel = 2'h2;
            default:       reg_sel = 2'h3;
        endcase
    endfunction : reg_sel

    logic iso_bad;
    assign iso_bad = s_reg.iso && !s_reg.dual;

    always_comb begin
        s_next = s_reg;
        s_next.hs_valid = 1'b0;
        s_next.tx_valid = 1'b0;
        s_next.tx_last  = 1'b0;
        s_next.tx_zero  = 1'b0;

        // ********************************************
        // register bus
        // ********************************************
        if (s_axi_awvalid_i && s_reg.awrdy) begin
            s_next.aw_got = 1'b1;
            s_next.awrdy  = 1'b0;
            s_next.awaddr = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && s_reg.wrdy) begin
            s_next.w_got = 1'b1;
            s_next.wrdy  = 1'b0;
            s_next.wdata = s_axi_wdata_i;
            s_next.wstrb = s_axi_wstrb_i;
        end
        if (s_reg.bvalid && s_axi_bready_i) begin
            s_next.bvalid = 1'b0;
        end
        if (s_reg.aw_got && s_reg.w_got && !s_reg.bvalid) begin
            s_next.aw_got = 1'b0;
            s_next.w_got  = 1'b0;
            s_next.awrdy  = 1'b1;
            s_next.wrdy   = 1'b1;
            s_next.bvalid = 1'b1;
            s_next.bresp  = `USBE_RESP_OKAY;
            unique case (reg_sel(s_reg.awaddr))
                2'h0: begin
                    if (s_reg.wstrb[0]) begin
                        // flags clear on writing 0, writing 1 leaves them alone
                        if (!s_reg.wdata[`USBE_B_TXDONE])   s_next.tx_done    = 1'b0;
                        if (!s_reg.wdata[`USBE_B_STALLSNT]) s_next.stall_sent = 1'b0;
                        if (!s_reg.wdata[`USBE_B_SETUP] && s_reg.setup_rcv) begin
                            s_next.setup_rcv = 1'b0;
                            s_next.rptr      = 7'h00;
                        end
                        for (int b = 0; b < 2; b++) begin
                            if (!s_reg.wdata[b == 0 ? `USBE_B_RXBK0 : `USBE_B_RXBK1]
                                && s_reg.full[b]) begin
                                s_next.full[b] = 1'b0;
                                if (s_reg.rd_bank == b[0]) begin
                                    s_next.rd_bank = s_reg.dual ? !b[0] : 1'b0;
                                    s_next.rptr    = 7'h00;
                                end
                            end
                        end
                        if (s_reg.wdata[`USBE_B_ARMED] && !s_reg.armed) begin
                            s_next.armed    = 1'b1;
                            s_next.q_bank   = s_reg.cpu_bank;
                            s_next.q_len    = s_reg.wptr;
                            s_next.wptr     = 7'h00;
                            // second bank opens to firmware at once
                            s_next.cpu_bank = s_reg.dual ? !s_reg.cpu_bank : 1'b0;
                        end else if (!s_reg.wdata[`USBE_B_ARMED]) begin
                            s_next.armed = 1'b0;
                        end
                        s_next.force_stall = s_reg.wdata[`USBE_B_FSTALL];
                        s_next.dual        = s_reg.wdata[`USBE_B_DUAL];
                    end
                    if (s_reg.wstrb[1]) s_next.iso = s_reg.wdata[`USBE_B_ISO];
                end
                2'h1: begin
                    if (s_reg.wstrb[0] && s_reg.wptr < `USBE_DEPTH) begin
                        s_next.mem[s_reg.cpu_bank][s_reg.wptr[5:0]] = s_reg.wdata[7:0];
                        s_next.wptr = s_reg.wptr + 7'h01;
                    end
                end
                2'h2: begin
                    // fifo pointers and bank ownership back to empty
                    s_next.wptr = 7'h00;
                    s_next.rptr = 7'h00;
                    s_next.cnt  = '0;
                    s_next.full = 2'h0;
                    s_next.armed    = `USBE_RST_FLAG;
                    s_next.cpu_bank = 1'b0;
                    s_next.rd_bank  = 1'b0;
                    s_next.rx_bank  = 1'b0;
                    s_next.st       = ST_IDLE;
                end
                default: s_next.bresp = `USBE_RESP_SLVERR;
            endcase
        end
        if (s_reg.rvalid && s_axi_rready_i) begin
            s_next.rvalid = 1'b0;
            s_next.arrdy  = 1'b1;
        end
        if (s_axi_arvalid_i && s_reg.arrdy) begin
            s_next.arrdy  = 1'b0;
            s_next.rvalid = 1'b1;
            s_next.rresp  = `USBE_RESP_OKAY;
            s_next.rdata  = 32'h0000_0000;
            unique case (reg_sel(s_axi_araddr_i))
                2'h0: s_next.rdata = {9'h000, s_reg.cnt[s_reg.rd_bank], 7'h00, s_reg.iso,
                                      s_reg.dual, s_reg.full[1], s_reg.force_stall,
                                      s_reg.armed, s_reg.stall_sent, s_reg.setup_rcv,
                                      s_reg.full[0], s_reg.tx_done};
                2'h1: begin
                    // a read pops one received byte
                    s_next.rdata[7:0] = s_reg.mem[s_reg.rd_bank][s_reg.rptr[5:0]];
                    if (s_reg.rptr < s_reg.cnt[s_reg.rd_bank]) s_next.rptr = s_reg.rptr + 7'h01;
                end
                2'h2: ;
                default: s_next.rresp = `USBE_RESP_SLVERR;
            endcase
        end

        // ********************************************
        // link side; applied last so hardware sets win over clears
        // ********************************************
        unique case (s_reg.st)
            ST_IDLE: begin
                if (tok_valid_i && !iso_bad) begin
                    s_next.uptr = 7'h00;
                    if (tok_pid_i == `USBE_PID_IN) begin
                        if (s_reg.force_stall) begin
                            s_next.hs_valid   = 1'b1;
                            s_next.hs_code    = `USBE_HS_STALL;
                            s_next.stall_sent = 1'b1;
                        end else if (s_reg.armed) begin
                            s_next.armed   = 1'b0;
                            s_next.tx_bank = s_reg.q_bank;
                            s_next.tx_len  = s_reg.q_len;
                            s_next.st      = ST_TX;
                        end else begin
                            s_next.hs_valid = 1'b1;
                            s_next.hs_code  = `USBE_HS_NAK;
                        end
                    end else begin
                        s_next.st         = ST_RX;
                        s_next.rx_setup   = (tok_pid_i == `USBE_PID_SETUP);
                        s_next.rx_tgt     = s_reg.dual ? s_reg.rx_bank : 1'b0;
                        s_next.rx_discard = 1'b0;
                        s_next.rx_hs      = `USBE_HS_ACK;
                        if (tok_pid_i == `USBE_PID_SETUP) begin
                            s_next.rx_tgt = 1'b0;
                        end else if (s_reg.force_stall) begin
                            s_next.rx_discard = 1'b1;
                            s_next.rx_hs      = `USBE_HS_STALL;
                        end else if (s_reg.dual ? s_reg.full[s_reg.rx_bank]
                                                : (s_reg.full[0] || s_reg.setup_rcv)) begin
                            s_next.rx_discard = 1'b1;
                            s_next.rx_hs      = `USBE_HS_NAK;
                        end
                    end
                end
            end
            ST_RX: begin
                if (rx_valid_i && !s_reg.rx_discard && s_reg.uptr < `USBE_DEPTH) begin
                    s_next.mem[s_reg.rx_tgt][s_reg.uptr[5:0]] = rx_data_i;
                    s_next.uptr = s_reg.uptr + 7'h01;
                end
                if (rx_end_i) begin
                    s_next.st       = ST_IDLE;
                    // isochronous data carries no handshake
                    s_next.hs_valid = !(s_reg.iso && !s_reg.rx_setup);
                    s_next.hs_code  = s_reg.rx_hs;
                    if (s_reg.rx_hs == `USBE_HS_STALL) s_next.stall_sent = 1'b1;
                    if (!s_reg.rx_discard) begin
                        s_next.cnt[s_reg.rx_tgt] = s_reg.uptr;
                        if (s_reg.rx_setup) begin
                            s_next.setup_rcv = 1'b1;
                            s_next.rd_bank   = 1'b0;
                            s_next.rptr      = 7'h00;
                        end else begin
                            s_next.full[s_reg.rx_tgt] = 1'b1;
                            if (s_reg.dual) s_next.rx_bank = !s_reg.rx_tgt;
                        end
                    end
                end
            end
            ST_TX: begin
                s_next.tx_valid = 1'b1;
                if (s_reg.tx_len == 7'h00) begin
                    s_next.tx_zero = 1'b1;
                    s_next.tx_last = 1'b1;
                end else begin
                    s_next.tx_data = s_reg.mem[s_reg.tx_bank][s_reg.uptr[5:0]];
                    s_next.tx_last = (s_reg.uptr + 7'h01 == s_reg.tx_len);
                    s_next.uptr    = s_reg.uptr + 7'h01;
                end
                if (s_next.tx_last) begin
                    s_next.st = s_reg.iso ? ST_IDLE : ST_WACK;
                    if (s_reg.iso) s_next.tx_done = 1'b1;
                end
            end
            ST_WACK: begin
                if (host_ack_i) begin
                    s_next.tx_done = 1'b1;
                    s_next.st      = ST_IDLE;
                end else if (tok_valid_i) begin
                    // no ack: re-queue the same bank; the host retries the token.
                    // safe because firmware arms the other bank only after done
                    s_next.armed  = 1'b1;
                    s_next.q_bank = s_reg.tx_bank;
                    s_next.q_len  = s_reg.tx_len;
                    s_next.st     = ST_IDLE;
                end
            end
        endcase
        s_next.irq = s_next.tx_done || (|s_next.full) || s_next.setup_rcv
                     || s_next.stall_sent;
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            s_reg       <= '0;
            s_reg.st    <= ST_IDLE;
            s_reg.awrdy <= `USBE_RST_RDY;
            s_reg.wrdy  <= `USBE_RST_RDY;
            s_reg.arrdy <= `USBE_RST_RDY;
            s_reg.armed <= `USBE_RST_FLAG;
        end else begin
            s_reg <= s_next;
        end
    end

    assign s_axi_awready_o = s_reg.awrdy;
    assign s_axi_wready_o  = s_reg.wrdy;
    assign s_axi_bvalid_o  = s_reg.bvalid;
    assign s_axi_bresp_o   = s_reg.bresp;
    assign s_axi_arready_o = s_reg.arrdy;
    assign s_axi_rvalid_o  = s_reg.rvalid;
    assign s_axi_rdata_o   = s_reg.rdata;
    assign s_axi_rresp_o   = s_reg.rresp;
    assign hs_valid_o      = s_reg.hs_valid;
    assign hs_code_o       = s_reg.hs_code;
    assign tx_valid_o      = s_reg.tx_valid;
    assign tx_data_o       = s_reg.tx_data;
    assign tx_last_o       = s_reg.tx_last;
    assign tx_zero_o       = s_reg.tx_zero;
    assign ep_irq_o        = s_reg.irq;

    // ********************************************
    // checks
    // ********************************************
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    logic in_tok;
    assign in_tok = tok_valid_i && tok_pid_i == `USBE_PID_IN && s_reg.st == ST_IDLE && !iso_bad;

    tx_done_ack_a: assert property ($rose(s_reg.tx_done) |-> $past(s_reg.st) == ST_WACK
        && $past(host_ack_i) || $past(s_reg.iso)) else $error("tx done without host ack");
    irq_pending_a: assert property (s_reg.tx_done || s_reg.stall_sent |-> ep_irq_o)
        else $error("irq low while flag set");
    in_nak_a: assert property (in_tok && !s_reg.armed && !s_reg.force_stall
        |=> hs_valid_o && hs_code_o == `USBE_HS_NAK) else $error("empty in not nakked");
    in_stall_a: assert property (in_tok && s_reg.force_stall
        |=> hs_valid_o && hs_code_o == `USBE_HS_STALL && s_reg.stall_sent)
        else $error("forced stall not sent");
    arm_take_a: assert property (in_tok && s_reg.armed && !s_reg.force_stall
        |=> !s_reg.armed && s_reg.st == ST_TX ##1 tx_valid_o) else $error("armed bank not taken");
    out_busy_a: assert property (tok_valid_i && tok_pid_i == `USBE_PID_OUT
        && s_reg.st == ST_IDLE && !s_reg.dual && s_reg.full[0] && !iso_bad
        |=> s_reg.rx_discard) else $error("busy single bank not refused");
    setup_ack_a: assert property (s_reg.st == ST_RX && rx_end_i && s_reg.rx_setup
        |=> hs_valid_o && hs_code_o == `USBE_HS_ACK && s_reg.setup_rcv)
        else $error("setup not acked");
    bank1_dual_a: assert property ($rose(s_reg.full[1]) |-> $past(s_reg.dual)
        && $past(s_reg.st) == ST_RX) else $error("bank 1 filled without dual mode");
    iso_ignore_a: assert property (tok_valid_i && s_reg.st == ST_IDLE && iso_bad
        |=> s_reg.st == ST_IDLE && !hs_valid_o) else $error("iso on single bank served");

    in_acked_c: cover property (s_reg.st == ST_WACK && host_ack_i);
    both_full_c: cover property (s_reg.full == 2'h3);
    stall_c: cover property ($rose(s_reg.stall_sent));
endmodule : usbe_ep_txn

// file: usbe_host_model.sv
// host stand-in: tokens, out data packets and acks toward the endpoint
module usbe_host_model (
    input  wire logic       clock_i,
    input  wire logic       hs_valid_i,
    input  wire logic [1:0] hs_code_i,
    input  wire logic       tx_valid_i,
    input  wire logic [7:0] tx_data_i,
    input  wire logic       tx_last_i,
    input  wire logic       tx_zero_i,
    output logic            tok_valid_o,
    output logic [1:0]      tok_pid_o,
    output logic            rx_valid_o,
    output logic [7:0]      rx_data_o,
    output logic            rx_end_o,
    output logic            host_ack_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        tok_valid_o = 1'b0;
        tok_pid_o   = 2'h3;
        rx_valid_o  = 1'b0;
        rx_data_o   = 8'h5a;
        rx_end_o    = 1'b0;
        host_ack_o  = 1'b0;
    end
    task automatic token(input logic [1:0] pid);
        tok_valid_o <= 1'b1;
        tok_pid_o   <= pid;
        @(posedge clock_i);
        tok_valid_o <= 1'b0;
        // released pid lines show junk, not the last code
        tok_pid_o   <= ~pid;
    endtask : token
    task automatic send(input logic [1:0] pid, input logic [7:0] q[$],
                        output logic [1:0] hs, output bit got);
        token(pid);
        foreach (q[i]) begin
            rx_valid_o <= 1'b1;
            rx_data_o  <= q[i];
            @(posedge clock_i);
        end
        rx_valid_o <= 1'b0;
        rx_data_o  <= ~rx_data_o;
        rx_end_o   <= 1'b1;
        @(posedge clock_i);
        rx_end_o <= 1'b0;
        got = 0;
        repeat (4) begin
            @(posedge clock_i);
            if (!got && hs_valid_i) begin
                got = 1;
                hs  = hs_code_i;
            end
        end
    endtask : send
    task automatic fetch(input bit ack, output logic [7:0] q[$],
                         output logic [1:0] hs, output bit got);
        bit fin;
        q   = {};
        got = 0;
        fin = 0;
        token(2'h1);
        repeat (8) begin
            @(posedge clock_i);
            if (!fin && hs_valid_i) begin
                got = 1;
                hs  = hs_code_i;
                fin = 1;
            end
            if (!fin && tx_valid_i) begin
                if (!tx_zero_i) q.push_back(tx_data_i);
                fin = tx_last_i;
            end
        end
        if (ack && !got) begin
            host_ack_o <= 1'b1;
            @(posedge clock_i);
            host_ack_o <= 1'b0;
        end
    endtask : fetch
endmodule : usbe_host_model

// file: usbe_pkg.sv
// types of the endpoint transaction handler
`include "usbe_regs.svh"
package usbe_pkg;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_RX   = 4'b0010,
        ST_TX   = 4'b0100,
        ST_WACK = 4'b1000
    } usbe_st_t;

    typedef struct packed {
        usbe_st_t                st;
        logic [1:0][63:0][7:0]   mem;
        logic [1:0][6:0]         cnt;
        logic [1:0]              full;
        logic [6:0]              wptr, rptr, uptr, q_len, tx_len;
        logic                    cpu_bank, rd_bank, rx_bank, tx_bank, q_bank, rx_tgt;
        logic                    armed, tx_done, stall_sent, setup_rcv, force_stall, dual, iso;
        logic                    rx_discard, rx_setup;
        logic [1:0]              rx_hs;
        logic                    awrdy, wrdy, aw_got, w_got, bvalid, arrdy, rvalid;
        logic [7:0]              awaddr;
        logic [31:0]             wdata, rdata;
        logic [3:0]              wstrb;
        logic [1:0]              bresp, rresp;
        logic                    hs_valid, tx_valid, tx_last, tx_zero, irq;
        logic [1:0]              hs_code;
        logic [7:0]              tx_data;
    } usbe_state_t;
endpackage : usbe_pkg

// file: usbe_regs.svh
// register offsets, field positions, reset values and codes of the endpoint handler
`ifndef USBE_REGS_SVH
`define USBE_REGS_SVH
`define USBE_OFF_CSR     8'h00
`define USBE_OFF_FDR     8'h04
`define USBE_OFF_RST     8'h08
`define USBE_B_TXDONE    0
`define USBE_B_RXBK0     1
`define USBE_B_SETUP     2
`define USBE_B_STALLSNT  3
`define USBE_B_ARMED     4
`define USBE_B_FSTALL    5
`define USBE_B_RXBK1     6
`define USBE_B_DUAL      7
`define USBE_B_ISO       8
`define USBE_CNT_LSB     16
`define USBE_DEPTH       7'h40
`define USBE_HS_ACK      2'h0
`define USBE_HS_NAK      2'h1
`define USBE_HS_STALL    2'h2
`define USBE_PID_OUT     2'h0
`define USBE_PID_IN      2'h1
`define USBE_PID_SETUP   2'h2
`define USBE_RESP_OKAY   2'h0
`define USBE_RESP_SLVERR 2'h2
`define USBE_RST_FLAG    1'h0
`define USBE_RST_RDY     1'h1
`endif
